// ### logic/i2cm_core.sv
// Purpose: APB-controlled I2C master sequencer with interrupts and status.
// Assumes: Open-drain SCL/SDA with external pull-ups; APB slave, no wait states.
// Notes: Byte and acknowledge shifting live elsewhere and report through event inputs.
`timescale 1ns/1ps
module i2cm_core import i2cm_pkg::*; #(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input wire logic ref_clk_in, // System clock, 50 MHz.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB direction, 1 is write.
  input wire logic [7:0] paddr_in, // APB byte address.
  input wire logic [31:0] pwdata_in, // APB write data.
  output logic [31:0] prdata_out, // APB read data.
  output logic pready_out, // APB ready.
  output logic pslverr_out, // APB error on unmapped address.
  input wire logic scl_in, // SCL pin level.
  output logic scl_out, // SCL output value, always low.
  output logic scl_oe_out, // SCL pulled low while high.
  input wire logic sda_in, // SDA pin level.
  output logic sda_out, // SDA output value, always low.
  output logic sda_oe_out, // SDA pulled low while high.
  input wire logic [3:0] xfer_ev_in, // Pulses: rx data, rx ack, tx data, tx ack.
  input wire logic addr_valid_in, // Pulse: a received address is on addr_in.
  input wire logic [9:0] addr_in, // Received slave address.
  input wire logic addr_ten_in, // Received address is 10-bit.
  output logic [1:0] filter_hit_out, // Entries matching the last address.
  output logic busy_out, // Master busy level.
  output logic irq_out // Interrupt level.
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFS_IRQ_EN) || (a == OFS_STATUS) || (a == OFS_IRQ_PEND) ||
              (a == OFS_CMD) || (a == OFS_FILT0) || (a == OFS_FILT1);
  endfunction

  function automatic logic flt_match(input i2cm_filt_t f, input logic [9:0] a, input logic ten);
    if (!f.en || (f.ten != ten)) begin
      flt_match = 1'b0;
    end else if (ten) begin
      flt_match = (f.addr == a);
    end else begin
      flt_match = (f.addr[6:0] == a[6:0]);
    end
  endfunction

  function automatic logic [31:0] flt_word(input i2cm_filt_t f);
    flt_word = RST_WORD;
    flt_word[9:0] = f.addr;
    flt_word[FLT_TEN] = f.ten;
    flt_word[FLT_EN] = f.en;
  endfunction

  function automatic i2cm_filt_t flt_load(input logic [31:0] w);
    flt_load.addr = w[9:0];
    flt_load.ten = w[FLT_TEN];
    flt_load.en = w[FLT_EN];
  endfunction

  // ****************************************************************
  // Bus line synchronisers
  // ****************************************************************
  i2cm_line_t line_s;

  i2cm_sync #(
    .W(2)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({scl_in, sda_in}),
    .q_out(line_s)
  );

  // ****************************************************************
  // State and next-state logic
  // ****************************************************************
  i2cm_state_t s_r;
  i2cm_state_t s_nxt;
  logic acc;
  logic wr;
  logic need_hi;
  logic adv;
  logic tick;
  logic busy;
  logic [31:0] ev;
  logic [31:0] status;
  logic [31:0] rd;
  logic [2:0] dset;

  // ****************************************************************
  // Address filter entries
  // ****************************************************************
  // Entry views are kept as an array so that the comparators come from one loop.
  i2cm_filt_t filt [2];
  logic [1:0] match;

  assign filt[0] = s_r.filt0;
  assign filt[1] = s_r.filt1;

  for (genvar i = 0; i < 2; i++) begin : g_filt
    assign match[i] = flt_match(filt[i], addr_in, addr_ten_in);
  end

  always_comb begin
    s_nxt = s_r;
    ev = RST_WORD;
    dset = 3'b000;
    acc = psel_in && penable_in && addr_ok(paddr_in);
    wr = acc && pwrite_in;

    busy = (s_r.seq != SQ_IDLE) || (s_r.req != 4'h0);

    status = RST_WORD;
    status[ST_BUSY] = busy;
    status[ST_START] = s_r.req[0];
    status[ST_STOP] = s_r.req[1];
    status[ST_DROP] = s_r.req[2];
    status[ST_RECOVER] = s_r.req[3];
    status[ST_DROPPED_LO+2:ST_DROPPED_LO] = s_r.dropped;

    // Waits for a released SCL stall the half-period count, so a slave may stretch the clock.
    need_hi = (s_r.seq == SQ_START_SDA) || (s_r.seq == SQ_RESTART_SCL) ||
              (s_r.seq == SQ_STOP_SCL) || (s_r.seq == SQ_REC_HIGH);
    adv = !need_hi || line_s.scl;
    // A slave still holding SDA stalls the restart count, so it cannot run past its end and hang.
    if (s_r.seq == SQ_RESTART_SCL) begin
      adv = adv && line_s.sda;
    end
    tick = adv && (s_r.cnt == 16'(HALF_CYC - 1));

    if (s_r.req[2] && (s_r.seq != SQ_DROP)) begin
      dset = {s_r.req[3], s_r.req[1], s_r.req[0]};
      s_nxt.req[0] = 1'b0;
      s_nxt.req[1] = 1'b0;
      s_nxt.req[3] = 1'b0;
      s_nxt.restart = 1'b0;
      s_nxt.seq = SQ_DROP;
    end else begin
      unique case (s_r.seq)
        SQ_IDLE: begin
          if (s_r.req[3]) begin
            s_nxt.pulses = 4'h0;
            s_nxt.seq = SQ_REC_LOW;
          end else if (s_r.req[0]) begin
            s_nxt.seq = SQ_START_SDA;
          end else if (s_r.req[1]) begin
            // No frame to close, so the stop completes at once.
            s_nxt.req[1] = 1'b0;
            ev[IRQ_END] = 1'b1;
          end
        end
        SQ_START_SDA: begin
          if (tick) begin
            s_nxt.seq = SQ_START_SCL;
          end
        end
        SQ_START_SCL: begin
          if (tick) begin
            s_nxt.req[0] = 1'b0;
            s_nxt.restart = 1'b0;
            ev[IRQ_RESTART] = s_r.restart;
            ev[IRQ_START] = !s_r.restart;
            s_nxt.seq = SQ_FRAME;
          end
        end
        SQ_FRAME: begin
          if (s_r.req[0]) begin
            s_nxt.seq = SQ_RESTART_SDA;
          end else if (s_r.req[1]) begin
            s_nxt.seq = SQ_STOP_SDA;
          end
        end
        SQ_RESTART_SDA: begin
          if (tick) begin
            s_nxt.seq = SQ_RESTART_SCL;
          end
        end
        SQ_RESTART_SCL: begin
          if (tick && line_s.sda) begin
            s_nxt.seq = SQ_START_SDA;
          end
        end
        SQ_STOP_SDA: begin
          if (tick) begin
            s_nxt.seq = SQ_STOP_SCL;
          end
        end
        SQ_STOP_SCL: begin
          if (tick) begin
            s_nxt.seq = SQ_STOP_REL;
          end
        end
        SQ_STOP_REL: begin
          if (tick) begin
            s_nxt.req[1] = 1'b0;
            ev[IRQ_END] = 1'b1;
            s_nxt.seq = SQ_IDLE;
          end
        end
        SQ_REC_LOW: begin
          if (tick) begin
            s_nxt.seq = SQ_REC_HIGH;
          end
        end
        SQ_REC_HIGH: begin
          if (tick) begin
            // Stops early once the slave lets SDA go, and gives up after the last pulse.
            if (line_s.sda || (s_r.pulses == RECOVER_PULSES - 4'h1)) begin
              s_nxt.req[3] = 1'b0;
              s_nxt.seq = SQ_IDLE;
            end else begin
              s_nxt.pulses = s_r.pulses + 4'h1;
              s_nxt.seq = SQ_REC_LOW;
            end
          end
        end
        SQ_DROP: begin
          // Lines are already released here; the drop event fires as the master goes idle.
          s_nxt.req[2] = 1'b0;
          ev[IRQ_DROP] = 1'b1;
          s_nxt.seq = SQ_IDLE;
        end
      endcase
    end

    // The count restarts on every change of state; in idle and in a frame nothing waits on it.
    if (s_nxt.seq != s_r.seq) begin
      s_nxt.cnt = 16'h0000;
    end else if (adv) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    // The clock generator runs whenever the sequencer is out of idle.
    ev[IRQ_CLKGEN_BEGIN] = (s_r.seq == SQ_IDLE) && (s_nxt.seq != SQ_IDLE);
    ev[IRQ_CLKGEN_LEAVE] = (s_r.seq != SQ_IDLE) && (s_nxt.seq == SQ_IDLE);
    ev[3:0] = xfer_ev_in;

    if (addr_valid_in) begin
      s_nxt.hit = match;
      ev[IRQ_FILTER] = |s_nxt.hit;
    end

    // Requests written this cycle are ORed in after the sequencer, so a completion never eats them.
    if (wr && (paddr_in == OFS_CMD)) begin
      s_nxt.req = s_nxt.req | {pwdata_in[ST_RECOVER], pwdata_in[ST_DROP], pwdata_in[ST_STOP],
                               pwdata_in[ST_START] | pwdata_in[CMD_RESTART]};
      s_nxt.restart = s_nxt.restart | pwdata_in[CMD_RESTART];
    end
    if (wr && (paddr_in == OFS_IRQ_EN)) begin
      s_nxt.irq_en = pwdata_in & IRQ_VALID;
    end
    if (wr && (paddr_in == OFS_FILT0)) begin
      s_nxt.filt0 = flt_load(pwdata_in);
    end
    if (wr && (paddr_in == OFS_FILT1)) begin
      s_nxt.filt1 = flt_load(pwdata_in);
    end

    // write one to clear, set wins
    s_nxt.pend = (s_r.pend & ~((wr && (paddr_in == OFS_IRQ_PEND)) ? pwdata_in : RST_WORD)) |
                 (ev & IRQ_VALID);
    s_nxt.dropped = (s_r.dropped & ~((wr && (paddr_in == OFS_STATUS)) ?
                     pwdata_in[ST_DROPPED_LO+2:ST_DROPPED_LO] : 3'b000)) | dset;

    // Read data is captured in the setup cycle and shown in the access cycle.
    unique case (paddr_in)
      OFS_IRQ_EN: rd = s_r.irq_en;
      OFS_STATUS: rd = status;
      OFS_IRQ_PEND: rd = s_r.pend;
      OFS_FILT0: rd = flt_word(s_r.filt0);
      OFS_FILT1: rd = flt_word(s_r.filt1);
      default: rd = RST_WORD;
    endcase
    if (psel_in && !penable_in) begin
      s_nxt.prdata = rd;
    end

    s_nxt.drv.scl = (s_nxt.seq == SQ_START_SCL) || (s_nxt.seq == SQ_FRAME) ||
                    (s_nxt.seq == SQ_RESTART_SDA) || (s_nxt.seq == SQ_STOP_SDA) ||
                    (s_nxt.seq == SQ_REC_LOW);
    s_nxt.drv.sda = (s_nxt.seq == SQ_START_SDA) || (s_nxt.seq == SQ_START_SCL) ||
                    (s_nxt.seq == SQ_STOP_SDA) || (s_nxt.seq == SQ_STOP_SCL);
    s_nxt.irq = |(s_nxt.pend & s_nxt.irq_en);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_out = s_r.prdata;
  // No wait states: every access phase completes in its first cycle.
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok(paddr_in);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = s_r.drv.scl;
  assign sda_oe_out = s_r.drv.sda;
  assign filter_hit_out = s_r.hit;
  assign busy_out = busy;
  assign irq_out = s_r.irq;

endmodule

// ### logic/i2cm_pkg.sv
// Purpose: Shared constants and types of the I2C master sequencer block.
// Assumes: 50 MHz ref_clk_in, APB register access with 32-bit data.
// Notes: Offsets are byte addresses; each register takes one aligned word.
package i2cm_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_FILT0 = 8'h10;
  localparam logic [7:0] OFS_FILT1 = 8'h14;

  localparam int IRQ_RESTART = 5;
  localparam int IRQ_START = 4;
  localparam int IRQ_END = 6;
  localparam int IRQ_DROP = 7;
  localparam int IRQ_CLKGEN_LEAVE = 15;
  localparam int IRQ_CLKGEN_BEGIN = 16;
  localparam int IRQ_FILTER = 17;
  localparam logic [31:0] IRQ_VALID = 32'h0003_80FF;

  // Status bits; command bits 4..7 share the request positions.
  localparam int ST_BUSY = 0;
  localparam int ST_START = 4;
  localparam int ST_STOP = 5;
  localparam int ST_DROP = 6;
  localparam int ST_RECOVER = 7;
  localparam int ST_DROPPED_LO = 9;
  localparam int CMD_RESTART = 8;

  localparam int FLT_TEN = 14;
  localparam int FLT_EN = 15;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam logic [3:0] RECOVER_PULSES = 4'h9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_START_SDA, SQ_START_SCL, SQ_FRAME, SQ_RESTART_SDA, SQ_RESTART_SCL,
    SQ_STOP_SDA, SQ_STOP_SCL, SQ_STOP_REL, SQ_REC_LOW, SQ_REC_HIGH, SQ_DROP
  } i2cm_seq_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_line_t;

  typedef struct packed {
    logic en;
    logic ten;
    logic [9:0] addr;
  } i2cm_filt_t;

  // Request bits: [0] start, [1] stop, [2] drop, [3] recover.
  typedef struct packed {
    logic [31:0] irq_en;
    logic [31:0] pend;
    logic [3:0] req;
    logic restart;
    logic [2:0] dropped;
    i2cm_filt_t filt0;
    i2cm_filt_t filt1;
    i2cm_seq_t seq;
    logic [15:0] cnt;
    logic [3:0] pulses;
    logic [31:0] prdata;
    logic [1:0] hit;
    i2cm_line_t drv;
    logic irq;
  } i2cm_state_t;

endpackage

// ### logic/i2cm_sync.sv
// Purpose: Two-stage synchroniser for the sampled bus lines.
// Assumes: Inputs are asynchronous to ref_clk_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module i2cm_sync import i2cm_pkg::*; #(
  parameter int W = 2
) (
  input wire logic ref_clk_in, // System clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic [W-1:0] d_in, // Asynchronous level.
  output logic [W-1:0] q_out // Synchronised level.
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // Lines idle high on an I2C bus, so reset to released.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

// ### sim/i2cm_core_asserts.sv
// Purpose: Port-level checks of the I2C master sequencer.
// Assumes: Sees only the ports of i2cm_core.
// Notes: Enable and pending state is inferred from the bus writes.
`timescale 1ns/1ps
module i2cm_core_asserts import i2cm_pkg::*; #(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input wire logic ref_clk_in, // Clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB direction.
  input wire logic [7:0] paddr_in, // APB address.
  input wire logic [31:0] pwdata_in, // APB write data.
  input wire logic [31:0] prdata_out, // APB read data.
  input wire logic pready_out, // APB ready.
  input wire logic pslverr_out, // APB error.
  input wire logic scl_in, // SCL level.
  input wire logic scl_out, // SCL value.
  input wire logic scl_oe_out, // SCL pull.
  input wire logic sda_in, // SDA level.
  input wire logic sda_out, // SDA value.
  input wire logic sda_oe_out, // SDA pull.
  input wire logic [3:0] xfer_ev_in, // Transfer events.
  input wire logic addr_valid_in, // Address strobe.
  input wire logic [9:0] addr_in, // Address.
  input wire logic addr_ten_in, // 10-bit flag.
  input wire logic [1:0] filter_hit_out, // Filter hits.
  input wire logic busy_out, // Busy.
  input wire logic irq_out // Interrupt.
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic wr;
  logic cmd;
  logic quiet;
  assign wr = psel_in && penable_in && pwrite_in;
  assign cmd = wr && paddr_in == OFS_CMD;
  assign quiet = !busy_out && xfer_ev_in == 4'h0 && !addr_valid_in;
  busy_oe_a: assert property ((scl_oe_out || sda_oe_out) |-> busy_out)
    else $error("Bus driven while not busy.");
  busy_cmd_a: assert property (cmd && (pwdata_in[ST_START] || pwdata_in[ST_DROP] || pwdata_in[ST_RECOVER])
    |-> ##[1:2] busy_out) else $error("Request did not raise busy.");
  drop_release_a: assert property (cmd && pwdata_in[ST_DROP] |-> ##[1:3] (!scl_oe_out && !sda_oe_out))
    else $error("Drop did not release the lines.");
  drop_idle_a: assert property (cmd && pwdata_in == 32'h0000_0040 |-> ##[2:4] !busy_out)
    else $error("Drop did not return to idle.");
  start_order_a: assert property ($rose(sda_oe_out) && !$past(scl_oe_out) |-> !scl_oe_out)
    else $error("Start pulled SCL with SDA.");
  filt_hold_a: assert property (!$past(addr_valid_in) |-> $stable(filter_hit_out))
    else $error("Filter hits moved without an address.");
  irq_mask_a: assert property (wr && paddr_in == OFS_IRQ_EN && pwdata_in == 32'h0 |-> ##2 !irq_out)
    else $error("Interrupt stayed up with all enables off.");
  irq_clear_a: assert property (wr && paddr_in == OFS_IRQ_PEND && pwdata_in == 32'hFFFF_FFFF && quiet
    ##1 quiet |-> ##1 !irq_out) else $error("Interrupt stayed up after clearing all flags.");
  cover property (cmd && pwdata_in[ST_DROP]);
  cover property ($rose(irq_out));
  cover property (addr_valid_in ##1 filter_hit_out != 2'b00);
endmodule
bind i2cm_core i2cm_core_asserts #(.HALF_CYC(HALF_CYC)) i2cm_core_asserts_inst (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .xfer_ev_in(xfer_ev_in), .addr_valid_in(addr_valid_in), .addr_in(addr_in), .addr_ten_in(addr_ten_in),
  .filter_hit_out(filter_hit_out), .busy_out(busy_out), .irq_out(irq_out));

// ### sim/i2cm_core_bench.sv
// Purpose: Self-checking bench of the I2C master sequencer.
// Assumes: HALF_CYC of 4 gives the 160 ns link clock.
// Notes: The model variables below give the enable and pending words after writes; other expected words are literals.
`timescale 1ns/1ps
module i2cm_core_bench import i2cm_pkg::*; ;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [3:0] xfer_ev_in = 4'h0;
  logic addr_valid_in = 1'b0;
  logic [9:0] addr_in = 10'h000;
  logic addr_ten_in = 1'b0;
  logic arm = 1'b0;
  logic [3:0] hold = 4'h3;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, scl_out, scl_oe_out, sda_out, sda_oe_out, busy_out, irq_out, sl_oe, err;
  logic [1:0] filter_hit_out;
  logic scl_w, sda_w;
  logic [31:0] q, en_m, pend_m, r;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n_start = 0;
  int n_stop = 0;
  int s0, k;
  int cbit[3] = '{ST_START, ST_STOP, ST_RECOVER};
  assign scl_w = !scl_oe_out;
  assign sda_w = !(sda_oe_out || sl_oe);
  always #10 ref_clk_in = !ref_clk_in;
  always @(negedge sda_w) if (scl_w) n_start++;
  always @(posedge sda_w) if (scl_w) n_stop++;
  i2cm_core #(.HALF_CYC(4)) i2cm_core_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .xfer_ev_in(xfer_ev_in), .addr_valid_in(addr_valid_in), .addr_in(addr_in),
    .addr_ten_in(addr_ten_in), .filter_hit_out(filter_hit_out), .busy_out(busy_out), .irq_out(irq_out));
  i2cm_slave_model i2cm_slave_model_inst (.scl_in(scl_w), .arm_in(arm), .hold_in(hold), .sda_oe_out(sl_oe));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_out !== 1'b1) @(posedge ref_clk_in);
    q = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic wait_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    q = ~v;
    for (i = 0; i < 300 && (q & m) !== v; i++) apb(1'b0, a, 32'h0000_0000);
    chk(q & m, v);
  endtask
  task automatic pulse_arm(input logic [3:0] h);
    @(posedge ref_clk_in);
    hold <= h;
    arm <= 1'b1;
    @(posedge ref_clk_in);
    arm <= 1'b0;
  endtask
  task automatic ad(input logic [9:0] a, input logic t, input logic [1:0] e);
    @(posedge ref_clk_in);
    addr_valid_in <= 1'b1;
    addr_in <= a;
    addr_ten_in <= t;
    @(posedge ref_clk_in);
    addr_valid_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk(filter_hit_out, e);
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'haab5));
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rdc(OFS_IRQ_EN, 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0000);
    rdc(OFS_IRQ_PEND, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
    chk(err, 1'b1);
    r = $urandom();
    apb(1'b1, OFS_IRQ_EN, r);
    en_m = r & IRQ_VALID;
    rdc(OFS_IRQ_EN, en_m);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_000F);
    en_m = 32'h0000_000F;
    @(posedge ref_clk_in);
    xfer_ev_in <= 4'($urandom_range(1, 15));
    @(posedge ref_clk_in);
    pend_m = 32'(xfer_ev_in);
    xfer_ev_in <= 4'h0;
    rdc(OFS_IRQ_PEND, pend_m);
    chk(irq_out, 1'b1);
    r = $urandom() & 32'h0000_000F;
    apb(1'b1, OFS_IRQ_PEND, r);
    pend_m = pend_m & ~r;
    rdc(OFS_IRQ_PEND, pend_m);
    chk(irq_out, 32'(pend_m != 0));
    apb(1'b1, OFS_IRQ_PEND, 32'hFFFF_FFFF);
    apb(1'b1, OFS_IRQ_EN, 32'hFFFF_FFFF);
    $display("Register and interrupt test done.");
    s0 = n_start;
    apb(1'b1, OFS_CMD, 32'h0000_0010);
    rdc(OFS_STATUS, 32'h0000_0011);
    chk(busy_out, 1'b1);
    wait_rd(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
    rdc(OFS_IRQ_PEND, 32'h0001_0010);
    chk(irq_out, 1'b1);
    k = n_stop;
    apb(1'b1, OFS_CMD, 32'h0000_0100);
    wait_rd(OFS_IRQ_PEND, 32'h0000_0020, 32'h0000_0020);
    chk(n_stop - k, 0);
    chk(n_start - s0, 2);
    apb(1'b1, OFS_IRQ_PEND, 32'hFFFF_FFFF);
    apb(1'b1, OFS_CMD, 32'h0000_0020);
    rdc(OFS_STATUS, 32'h0000_0021);
    wait_rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
    chk(n_stop - k, 1);
    rdc(OFS_IRQ_PEND, 32'h0000_8040);
    $display("Start, restart and stop test done.");
    for (k = 0; k < 3; k++) begin
      apb(1'b1, OFS_IRQ_PEND, 32'hFFFF_FFFF);
      if (k == 1) apb(1'b1, OFS_CMD, 32'h0000_0010);
      if (k == 1) wait_rd(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
      if (k == 2) pulse_arm(4'hF);
      apb(1'b1, OFS_CMD, 32'h1 << cbit[k]);
      apb(1'b1, OFS_CMD, 32'h0000_0040);
      rdc(OFS_STATUS, 32'h0000_0041 | (32'h1 << (ST_DROPPED_LO + k)));
      wait_rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
      rdc(OFS_STATUS, 32'h1 << (ST_DROPPED_LO + k));
      chk(scl_oe_out | sda_oe_out, 1'b0);
      chk({scl_out, sda_out}, 2'b00);
      chk(busy_out, 1'b0);
      apb(1'b0, OFS_IRQ_PEND, 32'h0000_0000);
      chk(q[IRQ_DROP], 1'b1);
      apb(1'b1, OFS_STATUS, 32'h1 << (ST_DROPPED_LO + k));
      rdc(OFS_STATUS, 32'h0000_0000);
    end
    pulse_arm(4'($urandom_range(1, 5)));
    apb(1'b1, OFS_CMD, 32'h0000_0080);
    rdc(OFS_STATUS, 32'h0000_0081);
    wait_rd(OFS_STATUS, 32'h0000_0081, 32'h0000_0000);
    chk(sda_w, 1'b1);
    $display("Drop and recover test done.");
    apb(1'b1, OFS_FILT0, 32'h0000_8030);
    apb(1'b1, OFS_FILT1, 32'h0000_C155);
    ad({3'($urandom()), 7'h30}, 1'b0, 2'b01);
    ad(10'h155, 1'b1, 2'b10);
    apb(1'b1, OFS_FILT0, 32'h0000_0030);
    ad(10'h030, 1'b0, 2'b00);
    apb(1'b0, OFS_IRQ_PEND, 32'h0000_0000);
    chk(q[IRQ_FILTER], 1'b1);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    repeat (3) @(posedge ref_clk_in);
    chk(irq_out, 1'b0);
    $display("Filter test done.");
    summarize();
  end
endmodule

// ### sim/i2cm_slave_model.sv
// Purpose: Slave that can hold SDA low for a number of SCL pulses.
// Assumes: Bus wires with pull-ups are resolved by the bench.
// Notes: SDA is let go while SCL is low, so no stop is faked on release.
`timescale 1ns/1ps
module i2cm_slave_model (
  input wire logic scl_in, // SCL wire level.
  input wire logic arm_in, // Rising edge starts holding SDA.
  input wire logic [3:0] hold_in, // SCL pulses to hold for.
  output logic sda_oe_out // Pulls SDA low while high.
);
  int left = 0;
  assign sda_oe_out = left > 0;
  always @(posedge arm_in) left = hold_in;
  always @(negedge scl_in) if (left > 0) left = left - 1;
endmodule
